// >>> hdl/reset_cause_status_register.sv
// Purpose: reset cause and power-state register with apb access and interrupt
// Assumes: rst is the power-on reset; other device resets leave this block running
// Notes:   pin and analog detector inputs are synchronised before use
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "reset_cause_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - trap conflict reset sets flag at bit 15.
// - illegal opcode, address mode or pointer reset sets bit 14.
// - configuration mismatch reset sets bit 9.
// - master clear pin reset sets bit 7.
// - reset instruction sets bit 6.
// - watchdog time-out sets bit 4.
// - having been in Sleep sets bit 3.
// - having been in Idle sets bit 2.
// - brown-out reset sets bit 1.
// - power-on reset sets bit 0.
// - bit 5 written one enables watchdog, zero disables it.
// - watchdog configuration bits both one keep watchdog always enabled.
// - software may set or clear any flag without causing a reset.
// - bit 8 one keeps main regulator active in Sleep, else standby.
// - bit 11 one keeps flash regulator active in Sleep, else standby.
// - bits 13, 12 and 10 always read zero.
// - power-on clears everything except brown-out and power-on flags, which set.
// - each reset kind sets its own matching flag.
module reset_cause_status_register
  import reset_cause_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire apb_req_t   apbReq,
  output apb_rsp_t        apbRsp,
  input  wire cause_evt_t causeIn,
  input  wire logic       masterClearPinN,
  input  wire logic       brownoutDetect,
  input  wire logic [1:0] watchdogConfigEnable,
  output logic            watchdogEnable,
  output logic            mainRegulatorSleepActive,
  output logic            flashRegulatorSleepActive,
  output logic            irq
);

  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [15:0] irqStat_ff;
  logic [15:0] irqMask_ff;
  logic [15:0] evtVec;
  logic [15:0] byteEn;
  logic [15:0] wrMerged;
  logic [31:0] rdData;
  logic        rdErr;
  logic        access;
  logic        commit;
  logic        wrStatus;
  logic        wrIrqStat;
  logic        wrIrqMask;
  logic [1:0]  pinSync_ff;
  logic [1:0]  brownSync_ff;
  apb_rsp_t    rsp_ff;
  logic        watchdog_config_enable_ff;
  logic        mainReg_ff;
  logic        flashReg_ff;
  logic        irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers for the pin and the analog detector

  // two flops each; only the second stage is read by logic
  always_ff @(posedge clk) begin
    if (rst) begin
      pinSync_ff   <= 2'h3;
      brownSync_ff <= 2'h0;
    end else begin
      pinSync_ff   <= {pinSync_ff[0], masterClearPinN};
      brownSync_ff <= {brownSync_ff[0], brownoutDetect};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event vector in the register layout

  // pin and brown-out are levels: flag is set on every cycle they are active
  always_comb begin
    evtVec                     = 16'h0000;
    evtVec[`RCS_BIT_TRAP]      = causeIn.trapConflict;
    evtVec[`RCS_BIT_ILLEGAL]   = causeIn.illegalCondition;
    evtVec[`RCS_BIT_CFG_MISM]  = causeIn.configMismatch;
    evtVec[`RCS_BIT_EXT_PIN]   = ~pinSync_ff[1];
    evtVec[`RCS_BIT_SW_RESET]  = causeIn.softwareReset;
    evtVec[`RCS_BIT_WDT_TOUT]  = causeIn.watchdogTimeout;
    evtVec[`RCS_BIT_SLEEP]     = causeIn.sleepEntered;
    evtVec[`RCS_BIT_IDLE]      = causeIn.idleEntered;
    evtVec[`RCS_BIT_BROWNOUT]  = brownSync_ff[1];
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  // a request is committed at the edge where pready is seen high
  assign access    = apbReq.psel & apbReq.penable;
  assign commit    = access & rsp_ff.pready;
  assign wrStatus  = commit & apbReq.pwrite & (apbReq.paddr == `RCS_ADDR_STATUS);
  assign wrIrqStat = commit & apbReq.pwrite & (apbReq.paddr == `RCS_ADDR_IRQ_STAT);
  assign wrIrqMask = commit & apbReq.pwrite & (apbReq.paddr == `RCS_ADDR_IRQ_MASK);

  // byte lanes of the low half-word; upper lanes have no storage
  assign byteEn   = {{8{apbReq.pstrb[1]}}, {8{apbReq.pstrb[0]}}};
  assign wrMerged = (status_ff & ~byteEn) | (apbReq.pwdata[15:0] & byteEn);

  // read mux; unmapped addresses answer zero with an error
  always_comb begin
    rdData = 32'h0000_0000;
    rdErr  = 1'b0;
    unique case (apbReq.paddr)
      `RCS_ADDR_STATUS:   rdData = {16'h0000, status_ff & `RCS_IMPL_MASK};
      `RCS_ADDR_IRQ_STAT: rdData = {16'h0000, irqStat_ff};
      `RCS_ADDR_IRQ_MASK: rdData = {16'h0000, irqMask_ff};
      default:            rdErr  = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, data and error captured with pready

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_ff <= '0;
    end else if (access & ~rsp_ff.pready) begin
      rsp_ff.pready  <= 1'b1;
      rsp_ff.prdata  <= apbReq.pwrite ? 32'h0000_0000 : rdData;
      rsp_ff.pslverr <= rdErr;
    end else begin
      rsp_ff <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset cause register

  // software value first, then hardware events win over any clear
  always_comb begin
    nxt_status = wrStatus ? wrMerged : status_ff;
    nxt_status = (nxt_status | evtVec) & `RCS_IMPL_MASK;
  end

  // only power-on resets this register; other resets keep flags
  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= `RCS_PWR_ON_VALUE;
    end else begin
      status_ff <= nxt_status;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control outputs taken from the register

  // watchdog forced on by configuration, else follows software bit
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_config_enable_ff <= 1'b0;
    end else begin
      watchdog_config_enable_ff <= (watchdogConfigEnable == `RCS_WDT_CFG_FORCE)
                  | status_ff[`RCS_BIT_SW_WDT];
    end
  end

  // regulator sleep behaviour: one keeps the regulator active in Sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      mainReg_ff  <= 1'b0;
      flashReg_ff <= 1'b0;
    end else begin
      mainReg_ff  <= status_ff[`RCS_BIT_MAIN_REG];
      flashReg_ff <= status_ff[`RCS_BIT_FLASH_REG];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  // sticky, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_ff <= `RCS_IRQ_RESET;
    end else begin
      irqStat_ff <= ((irqStat_ff & ~(wrIrqStat ? wrMerged & byteEn : 16'h0000)) | evtVec)
                    & `RCS_EVENT_MASK;
    end
  end

  // mask of the same layout, one enables the bit onto irq
  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask_ff <= `RCS_IRQ_RESET;
    end else if (wrIrqMask) begin
      irqMask_ff <= ((irqMask_ff & ~byteEn) | (apbReq.pwdata[15:0] & byteEn)) & `RCS_EVENT_MASK;
    end
  end

  // level interrupt while any unmasked status bit is set
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irqStat_ff & irqMask_ff);
    end
  end

  assign apbRsp                    = rsp_ff;
  assign watchdogEnable            = watchdog_config_enable_ff;
  assign mainRegulatorSleepActive  = mainReg_ff;
  assign flashRegulatorSleepActive = flashReg_ff;
  assign irq                       = irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  // trap conflict pulse is recorded on the next edge
  property p_trap;
    @(posedge clk) disable iff (rst) causeIn.trapConflict |=> status_ff[`RCS_BIT_TRAP];
  endproperty
  a_trap: assert property (p_trap) else $error("trap flag not set");

  // illegal condition pulse is recorded on the next edge
  property p_illegal;
    @(posedge clk) disable iff (rst) causeIn.illegalCondition |=> status_ff[`RCS_BIT_ILLEGAL];
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal flag not set");

  // configuration mismatch pulse is recorded on the next edge
  property p_cfg_mism;
    @(posedge clk) disable iff (rst) causeIn.configMismatch |=> status_ff[`RCS_BIT_CFG_MISM];
  endproperty
  a_cfg_mism: assert property (p_cfg_mism) else $error("mismatch flag not set");

  // pin low is seen through the synchroniser three edges later
  property p_ext_pin;
    @(posedge clk) disable iff (rst) !masterClearPinN |-> ##3 status_ff[`RCS_BIT_EXT_PIN];
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("pin flag not set");

  // reset instruction pulse is recorded on the next edge
  property p_sw_reset;
    @(posedge clk) disable iff (rst) causeIn.softwareReset |=> status_ff[`RCS_BIT_SW_RESET];
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("sw reset flag not set");

  // watchdog time-out pulse is recorded on the next edge
  property p_wdt_tout;
    @(posedge clk) disable iff (rst) causeIn.watchdogTimeout |=> status_ff[`RCS_BIT_WDT_TOUT];
  endproperty
  a_wdt_tout: assert property (p_wdt_tout) else $error("timeout flag not set");

  // sleep and idle entry are recorded on the next edge
  property p_sleep;
    @(posedge clk) disable iff (rst) causeIn.sleepEntered |=> status_ff[`RCS_BIT_SLEEP];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flag not set");

  property p_idle;
    @(posedge clk) disable iff (rst) causeIn.idleEntered |=> status_ff[`RCS_BIT_IDLE];
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag not set");

  // brown-out level is seen through the synchroniser three edges later
  property p_brownout;
    @(posedge clk) disable iff (rst) brownoutDetect |-> ##3 status_ff[`RCS_BIT_BROWNOUT];
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out flag not set");

  // first edge after power-on shows only the two power flags
  property p_pwr_on;
    @(posedge clk) disable iff (rst) $fell(rst) |-> status_ff == `RCS_PWR_ON_VALUE;
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("power-on value wrong");

  // watchdog output follows the software bit one edge later
  property p_wdt_sw;
    @(posedge clk) disable iff (rst)
      (watchdogConfigEnable != `RCS_WDT_CFG_FORCE) |=> watchdogEnable == $past(status_ff[`RCS_BIT_SW_WDT]);
  endproperty
  a_wdt_sw: assert property (p_wdt_sw) else $error("watchdog enable wrong");

  // forced configuration keeps the watchdog on
  property p_wdt_force;
    @(posedge clk) disable iff (rst) (watchdogConfigEnable == `RCS_WDT_CFG_FORCE) |=> watchdogEnable;
  endproperty
  a_wdt_force: assert property (p_wdt_force) else $error("watchdog not forced");

  // a full write with no event stores the written implemented bits
  property p_sw_write;
    @(posedge clk) disable iff (rst) (wrStatus && evtVec == 16'h0000 && apbReq.pstrb[1:0] == 2'h3)
      |=> status_ff == ($past(apbReq.pwdata[15:0]) & `RCS_IMPL_MASK);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software write lost");

  // regulator outputs follow their bits one edge later
  property p_main_reg;
    @(posedge clk) disable iff (rst) 1'b1 |=> mainRegulatorSleepActive == $past(status_ff[`RCS_BIT_MAIN_REG]);
  endproperty
  a_main_reg: assert property (p_main_reg) else $error("main regulator wrong");

  property p_flash_reg;
    @(posedge clk) disable iff (rst) 1'b1 |=> flashRegulatorSleepActive == $past(status_ff[`RCS_BIT_FLASH_REG]);
  endproperty
  a_flash_reg: assert property (p_flash_reg) else $error("flash regulator wrong");

  // unimplemented bits read zero
  property p_unimpl;
    @(posedge clk) disable iff (rst) apbRsp.pready |-> (apbRsp.prdata[13:12] == 2'h0) && !apbRsp.prdata[10];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  // no write and no event leaves every flag unchanged
  property p_hold;
    @(posedge clk) disable iff (rst) (!wrStatus && evtVec == 16'h0000) |=> $stable(status_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("flag changed on its own");

  // an event wins over a clearing write in the same cycle
  property p_set_wins;
    @(posedge clk) disable iff (rst) (wrStatus && evtVec[`RCS_BIT_TRAP]) |=> status_ff[`RCS_BIT_TRAP];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to write");

endmodule

// >>> hdl/reset_cause_params.svh
// Purpose: offsets, field positions and reset values of the reset cause block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   macros only, no logic
`ifndef RESET_CAUSE_PARAMS_SVH
`define RESET_CAUSE_PARAMS_SVH

// register byte addresses
`define RCS_ADDR_STATUS   12'h000
`define RCS_ADDR_IRQ_STAT 12'h004
`define RCS_ADDR_IRQ_MASK 12'h008

// field positions of reset_cause_status
`define RCS_BIT_TRAP      15
`define RCS_BIT_ILLEGAL   14
`define RCS_BIT_FLASH_REG 11
`define RCS_BIT_CFG_MISM  9
`define RCS_BIT_MAIN_REG  8
`define RCS_BIT_EXT_PIN   7
`define RCS_BIT_SW_RESET  6
`define RCS_BIT_SW_WDT    5
`define RCS_BIT_WDT_TOUT  4
`define RCS_BIT_SLEEP     3
`define RCS_BIT_IDLE      2
`define RCS_BIT_BROWNOUT  1
`define RCS_BIT_PWR_ON    0

// value after power-on, implemented bits, event-driven bits
`define RCS_PWR_ON_VALUE  16'h0003
`define RCS_IMPL_MASK     16'hcbff
`define RCS_EVENT_MASK    16'hc2df

// watchdog configuration code that forces the watchdog on
`define RCS_WDT_CFG_FORCE 2'h3

// interrupt registers after reset
`define RCS_IRQ_RESET     16'h0000
`endif

// >>> hdl/reset_cause_pkg.sv
// Purpose: carrier types of the reset cause block
// Assumes: 32-bit APB4 signalling
// Notes:   constants live in reset_cause_params.svh
package reset_cause_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // same-clock reset cause and power-state events, one-cycle pulses
  typedef struct packed {
    logic trapConflict;
    logic illegalCondition;
    logic configMismatch;
    logic softwareReset;
    logic watchdogTimeout;
    logic sleepEntered;
    logic idleEntered;
  } cause_evt_t;

endpackage

// >>> test/reset_source_model.sv
// Purpose: model of the reset source detectors around the reset cause block
// Assumes: same-clock cause pulses; pin and detector are slow levels
// Notes:   the bench calls fire() to raise one source
`timescale 1ns/1ps

module reset_source_model
  import reset_cause_pkg::*;
(
  input  wire logic clk,
  output cause_evt_t causeIn,
  output logic       masterClearPinN,
  output logic       brownoutDetect
);
  // quiet sources: no pulse, pin released high, detector idle
  initial begin
    causeIn = '0;
    masterClearPinN = 1'b1;
    brownoutDetect = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // raise source k; pin and detector stay active long enough for the synchroniser
  task automatic fire(input int k);
    @(posedge clk);
    if (k < 7) begin
      causeIn <= cause_evt_t'(7'h40 >> k);
    end else if (k == 7) begin
      masterClearPinN <= 1'b0;
    end else begin
      brownoutDetect <= 1'b1;
    end
    repeat (k < 7 ? 1 : 4) @(posedge clk);
    causeIn <= '0;
    masterClearPinN <= 1'b1;
    brownoutDetect <= 1'b0;
  endtask
endmodule

// >>> test/reset_cause_status_register_test.sv
// Purpose: self-checking bench of the reset cause register
// Assumes: one wait state apb slave, events visible within six cycles
// Notes:   random register values from a fixed seed, corners among them
`timescale 1ns/1ps
`include "reset_cause_params.svh"

module reset_cause_status_register_test;
  import reset_cause_pkg::*;
  logic       clk;
  logic       rst;
  apb_req_t   apbReq;
  apb_rsp_t   apbRsp;
  cause_evt_t causeIn;
  logic       masterClearPinN;
  logic       brownoutDetect;
  logic [1:0] watchdogConfigEnable;
  logic       watchdogEnable;
  logic       mainRegulatorSleepActive;
  logic       flashRegulatorSleepActive;
  logic       irq;
  int         errTotal;
  int         compares;
  logic [15:0] acc;
  logic [15:0] v;
  logic [31:0] rd;
  logic        err;

  reset_cause_status_register dut (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .causeIn(causeIn),
    .masterClearPinN(masterClearPinN), .brownoutDetect(brownoutDetect),
    .watchdogConfigEnable(watchdogConfigEnable), .watchdogEnable(watchdogEnable),
    .mainRegulatorSleepActive(mainRegulatorSleepActive),
    .flashRegulatorSleepActive(flashRegulatorSleepActive), .irq(irq));
  reset_source_model src (.clk(clk), .causeIn(causeIn), .masterClearPinN(masterClearPinN),
    .brownoutDetect(brownoutDetect));

  // free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // expectations
  // flag of each source, in the order fire() numbers them
  function automatic logic [15:0] bitOf(input int k);
    int p;
    case (k)
      0: p = `RCS_BIT_TRAP;
      1: p = `RCS_BIT_ILLEGAL;
      2: p = `RCS_BIT_CFG_MISM;
      3: p = `RCS_BIT_SW_RESET;
      4: p = `RCS_BIT_WDT_TOUT;
      5: p = `RCS_BIT_SLEEP;
      6: p = `RCS_BIT_IDLE;
      7: p = `RCS_BIT_EXT_PIN;
      default: p = `RCS_BIT_BROWNOUT;
    endcase
    return 16'h0001 << p;
  endfunction
  function automatic logic expWdt(input logic [15:0] s, input logic [1:0] c);
    return s[`RCS_BIT_SW_WDT] | (c == `RCS_WDT_CFG_FORCE);
  endfunction

  // verdict and comparisons
  task automatic giveVerdict();
    $display("compares=%0d errors=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= {16'h0000, wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (n == 16) begin
      errTotal++;
      giveVerdict();
    end
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] wd);
    apb(1'b1, a, wd, rd, err);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000, rd, err);
    chk(rd, {16'h0000, exp});
  endtask
  // write while source 0 pulses in the commit cycle; one wait state puts the commit on the fourth edge
  task automatic wrRace(input logic [11:0] a, input logic [15:0] wd);
    fork
      wr(a, wd);
      begin
        repeat (2) @(posedge clk);
        src.fire(0);
      end
    join
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    apbReq = '0;
    apbReq.pstrb = 4'hf;
    watchdogConfigEnable = 2'h0;
    rst = 1'b1;
    errTotal = 0;
    compares = 0;
    void'($urandom(32'hdf7de893));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdChk(`RCS_ADDR_STATUS, `RCS_PWR_ON_VALUE);
    rdChk(`RCS_ADDR_IRQ_STAT, `RCS_IRQ_RESET);
    rdChk(`RCS_ADDR_IRQ_MASK, `RCS_IRQ_RESET);
    // every source sets its own flag; earlier flags are kept
    wr(`RCS_ADDR_STATUS, 16'h0000);
    wr(`RCS_ADDR_IRQ_MASK, `RCS_EVENT_MASK);
    acc = 16'h0000;
    for (int k = 0; k < 9; k++) begin
      src.fire(k);
      repeat (6) @(posedge clk);
      acc = acc | bitOf(k);
      rdChk(`RCS_ADDR_STATUS, acc);
      rdChk(`RCS_ADDR_IRQ_STAT, bitOf(k));
      chkBit(irq, 1'b1);
      wr(`RCS_ADDR_IRQ_STAT, bitOf(k));
      repeat (2) @(posedge clk);
      chkBit(irq, 1'b0);
    end
    // a masked event is recorded but does not interrupt
    wr(`RCS_ADDR_IRQ_MASK, 16'h0000);
    src.fire(0);
    repeat (6) @(posedge clk);
    chkBit(irq, 1'b0);
    rdChk(`RCS_ADDR_IRQ_STAT, bitOf(0));
    wr(`RCS_ADDR_IRQ_MASK, bitOf(0));
    repeat (2) @(posedge clk);
    chkBit(irq, 1'b1);
    // an event in the commit cycle of a clearing write wins, in the flags and in irq status
    wrRace(`RCS_ADDR_STATUS, 16'h0000);
    rdChk(`RCS_ADDR_STATUS, bitOf(0));
    wrRace(`RCS_ADDR_IRQ_STAT, bitOf(0));
    rdChk(`RCS_ADDR_IRQ_STAT, bitOf(0));
    wr(`RCS_ADDR_IRQ_STAT, 16'hffff);
    // software writes of any value, with watchdog and regulator controls
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : (i == 2) ? 16'h0020 : 16'($urandom);
      @(posedge clk);
      watchdogConfigEnable <= (i < 2) ? 2'h3 : (i == 2) ? 2'h0 : 2'($urandom);
      wr(`RCS_ADDR_STATUS, v);
      rdChk(`RCS_ADDR_STATUS, v & `RCS_IMPL_MASK);
      repeat (2) @(posedge clk);
      chkBit(watchdogEnable, expWdt(v, watchdogConfigEnable));
      chkBit(mainRegulatorSleepActive, v[`RCS_BIT_MAIN_REG]);
      chkBit(flashRegulatorSleepActive, v[`RCS_BIT_FLASH_REG]);
      rdChk(`RCS_ADDR_IRQ_STAT, 16'h0000);
    end
    // unmapped places answer with an error and change nothing
    apb(1'b0, 12'h00c, 16'h0000, rd, err);
    chkBit(err, 1'b1);
    chk(rd, 32'h00000000);
    wr(12'h010, 16'h5a5a);
    rdChk(`RCS_ADDR_STATUS, v & `RCS_IMPL_MASK);
    // power-on reset in mid-run restores the power-on value
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdChk(`RCS_ADDR_STATUS, `RCS_PWR_ON_VALUE);
    rdChk(`RCS_ADDR_IRQ_MASK, `RCS_IRQ_RESET);
    chkBit(irq, 1'b0);
    giveVerdict();
  end
endmodule
